// file: jcc_chain_handshake.sv
// Chain-enable, error and completion handshake of the configuration port
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
module jcc_chain_handshake
   import jcc_pkg::*;
#(
   parameter int BIT_COUNT = 1024,
   parameter int INIT_TCKS = JCC_INIT_TCKS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Test port pins
   input wire logic tck,
   input wire logic tdi,
   input wire logic tms,
   output logic tdo,
   output logic tdoOe,
   // Bypass select, as decoded by the test port controller
   input wire logic bypassSel,
   // Configuration pins
   input wire logic chainEnableIn_n,
   input wire logic configRequest_n,
   input wire logic [1:0] schemeSelect,
   input wire logic serialConfigClock,
   input wire logic loadError,
   output logic chainEnableOut_n,
   output logic chainEnableOutOe,
   output logic configErrorLine_n,
   output logic configComplete,
   // Register port
   input wire logic [1:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   output logic irq
);
   // Straps are only reported, but they still cross from the board
   logic [1:0] schemeSync1, schemeSync2;
   logic strapClkSync1, strapClkSync2;

   jcc_tap_t sync1, sync2;
   logic tckLast, tckRise, tckFall;
   logic reqSync1, reqSync2, ceSync1, ceSync2, errSync1, errSync2;
   jcc_state_t state;
   // Shared by load and init; it restarts between the two
   logic [JCC_CNT_W-1:0] count;
   logic bypassBit;
   jcc_irq_t status, mask, events;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync1 <= '0;
         sync2 <= '0;
         {reqSync1, reqSync2, ceSync1, ceSync2} <= 4'h0;
         {errSync1, errSync2} <= 2'h0;
         tckLast <= 1'b0;
      end else begin
         sync1 <= '{tck: tck, tdi: tdi, tms: tms};
         sync2 <= sync1;
         reqSync1 <= configRequest_n;
         reqSync2 <= reqSync1;
         ceSync1 <= chainEnableIn_n;
         ceSync2 <= ceSync1;
         errSync1 <= loadError;
         errSync2 <= errSync1;
         tckLast <= sync2.tck;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         schemeSync1 <= 2'h0;
         schemeSync2 <= 2'h0;
         strapClkSync1 <= 1'b0;
         strapClkSync2 <= 1'b0;
      end else begin
         schemeSync1 <= schemeSelect;
         schemeSync2 <= schemeSync1;
         strapClkSync1 <= serialConfigClock;
         strapClkSync2 <= strapClkSync1;
      end
   end

   assign tckRise = sync2.tck & ~tckLast;
   assign tckFall = ~sync2.tck & tckLast;

   // Loading starts only while enabled and not held in reconfiguration
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= JCC_IDLE;
         count <= '0;
      end else if (!reqSync2) begin
         state <= JCC_IDLE;
         count <= '0;
      end else begin
         case (state)
            // The arming rise carries no bitstream bit
            JCC_IDLE: begin
               count <= '0;
               if (!ceSync2 && !bypassSel && tckRise) begin
                  state <= JCC_LOAD;
               end
            end
            JCC_LOAD: begin
               if (errSync2) begin
                  state <= JCC_FAIL;
               end else if (tckRise && !bypassSel) begin
                  if (count == JCC_CNT_W'(BIT_COUNT - 1)) begin
                     state <= JCC_INIT;
                     count <= '0;
                  end else begin
                     count <= count + 1'b1;
                  end
               end
            end
            JCC_INIT: begin
               if (errSync2) begin
                  state <= JCC_FAIL;
               end else if (tckRise) begin
                  if (count == JCC_CNT_W'(INIT_TCKS - 1)) begin
                     state <= JCC_DONE;
                  end else begin
                     count <= count + 1'b1;
                  end
               end
            end
            JCC_DONE: state <= JCC_DONE;
            JCC_FAIL: state <= JCC_FAIL;
            default: state <= JCC_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         configErrorLine_n <= 1'b1;
         configComplete <= 1'b0;
      end else begin
         configErrorLine_n <= (state != JCC_FAIL);
         configComplete <= (state == JCC_DONE);
      end
   end

   // chain enable held high until done, then driven low
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         chainEnableOut_n <= 1'b1;
         chainEnableOutOe <= 1'b1;
      end else begin
         chainEnableOut_n <= (state != JCC_DONE);
         chainEnableOutOe <= 1'b1;
      end
   end

   // single bypass stage, TDO changes on falling TCK
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bypassBit <= 1'b0;
         tdo <= 1'b0;
         tdoOe <= 1'b0;
      end else begin
         if (tckRise) begin
            bypassBit <= sync2.tdi;
         end
         // Enable changes only at a fall, so TDO never switches mid-bit
         if (tckFall) begin
            tdo <= bypassBit;
            tdoOe <= bypassSel;
         end
      end
   end

   // Sticky events; a new event wins over a clear in the same cycle
   // Each event is the first cycle spent in DONE or FAIL
   assign events.completed = (state == JCC_DONE) & ~configComplete;
   assign events.failed = (state == JCC_FAIL) & configErrorLine_n;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         status <= '0;
         mask <= '0;
      end else begin
         if (regWrite && regAddr == JCC_ADDR_MASK) begin
            mask <= regWdata[1:0];
         end
         if (regWrite && regAddr == JCC_ADDR_STATUS) begin
            status <= (status & ~jcc_irq_t'(regWdata[1:0])) | events;
         end else begin
            status <= status | events;
         end
      end
   end

   // Level output; it stays high until software clears or masks it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & mask);
      end
   end

   // Unmapped addresses read zero
   // State word: straps, synchronised pins, then the state code
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         regRdata <= '0;
      end else if (regRead) begin
         case (regAddr)
            JCC_ADDR_STATUS: regRdata <= {6'h0, status};
            JCC_ADDR_MASK: regRdata <= {6'h0, mask};
            JCC_ADDR_STATE: regRdata <= {schemeSync2, strapClkSync2,
                                         ceSync2, reqSync2, state};
            default: regRdata <= '0;
         endcase
      end else begin
         regRdata <= '0;
      end
   end
endmodule

// file: jcc_pkg.sv
// Package of constants and types for the chain configuration handshake
package jcc_pkg;
   // Extra TCK cycles needed after the last bitstream bit
   localparam int JCC_INIT_TCKS = 299;
   localparam int JCC_CNT_W = 16;
   localparam logic [1:0] JCC_SCHEME_PRODUCTION = 2'h0;
   // Register offsets
   localparam logic [1:0] JCC_ADDR_STATUS = 2'h0;
   localparam logic [1:0] JCC_ADDR_MASK = 2'h1;
   localparam logic [1:0] JCC_ADDR_STATE = 2'h2;

   typedef enum logic [2:0] {
      JCC_IDLE = 3'b000,
      JCC_LOAD = 3'b001,
      JCC_INIT = 3'b010,
      JCC_DONE = 3'b011,
      JCC_FAIL = 3'b100
   } jcc_state_t;

   // Test port pins after synchronisation
   typedef struct packed {
      logic tck;
      logic tdi;
      logic tms;
   } jcc_tap_t;

   // Interrupt event layout
   typedef struct packed {
      logic failed;
      logic completed;
   } jcc_irq_t;
endpackage

// file: jcc_chain_handshake_assertions.sv
// Checker of the chain handshake outputs
`timescale 1ns/100ps
module jcc_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Watched pins
   input wire logic bypassSel,
   input wire logic tdoOe,
   input wire logic chainEnableOut_n,
   input wire logic chainEnableOutOe,
   input wire logic configErrorLine_n,
   input wire logic configComplete
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_error_blocks_done: assert property (!configErrorLine_n |->
      !configComplete && chainEnableOut_n) else $error("error with done");
   a_done_clean: assert property ($rose(configComplete) |->
      configErrorLine_n) else $error("done while error line low");
   a_done_enables_next: assert property ($rose(configComplete) |->
      ##[0:2] !chainEnableOut_n) else $error("chain enable not low");
   a_enable_driven: assert property (chainEnableOutOe)
      else $error("chain enable output not driven");
   a_done_drives_low: assert property (configComplete |->
      chainEnableOutOe && !chainEnableOut_n)
      else $error("chain enable not driven low after done");
   a_bypass_drive: assert property ($rose(tdoOe) |->
      $past(bypassSel)) else $error("tdo driven outside bypass");
   a_enable_waits: assert property ($fell(chainEnableOut_n) |->
      ##[0:2] configComplete) else $error("chain enable low early");
   cover property ($rose(configComplete));
   cover property ($fell(configErrorLine_n));
   cover property ($rose(tdoOe));
endmodule
bind jcc_chain_handshake jcc_checker chk (.clk(clk), .reset(reset),
   .bypassSel(bypassSel), .tdoOe(tdoOe), .chainEnableOut_n(chainEnableOut_n),
   .chainEnableOutOe(chainEnableOutOe), .configComplete(configComplete),
   .configErrorLine_n(configErrorLine_n));

// file: jcc_host_model.sv
// Download host model that clocks the test port
`timescale 1ns/100ps
module jcc_host_model (
   // Test port drive
   output logic tck,
   output logic tdi
);
   // Clock stands low between bursts
   initial tck = 1'b0;
   initial tdi = 1'b0;
   task automatic pulse(input int n, input logic b);
      tdi = b;
      repeat (n) begin
         #62.5 tck = 1'b1;
         #62.5 tck = 1'b0;
      end
   endtask
endmodule

// file: tb_top.sv
// Self-checking bench of the chain configuration handshake
`timescale 1ns/100ps
`define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin \
   $display("MISMATCH %s exp %h got %h", n, e, v); error_cnt++; end end
module tb_top
   import jcc_pkg::*;
;
   logic clk = 1'b0, reset = 1'b1, bypassSel = 1'b0, loadError = 1'b0;
   logic tms = 1'b0, chainEnableIn_n = 1'b0, configRequest_n = 1'b1;
   logic serialConfigClock = 1'b0, regWrite = 1'b0, regRead = 1'b0;
   logic [1:0] schemeSelect = JCC_SCHEME_PRODUCTION, regAddr = 2'h0;
   logic [7:0] regWdata = 8'h00, regRdata;
   // chain enable out only read, as the next stage's enable
   logic tck, tdi, tdo, tdoOe, chainEnableOut_n, chainEnableOutOe, irq;
   logic configErrorLine_n, configComplete;
   int error_cnt = 0, total_checks = 0;
   always #5 clk = ~clk;
   jcc_host_model host (.*);
   jcc_chain_handshake #(.BIT_COUNT(8), .INIT_TCKS(3)) uut (.*);
   task settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      `CHK("regRdata", e, regRdata)
   endtask
   task t_config;
      settle(4);
      host.pulse(11, 1'b1);
      settle(10);
      `CHK("early done", 1'b0, configComplete)
      `CHK("early enable", 1'b1, chainEnableOut_n)
      host.pulse(1, 1'b1);
      settle(10);
      `CHK("done", 1'b1, configComplete)
      `CHK("enable out", 1'b0, chainEnableOut_n)
      `CHK("oe", 1'b1, chainEnableOutOe)
      rd(JCC_ADDR_STATUS, 8'h01);
      rd(JCC_ADDR_STATE, {5'h01, JCC_DONE});
      `CHK("irq masked", 1'b0, irq)
      wr(JCC_ADDR_MASK, 8'h03);
      settle(2);
      `CHK("irq", 1'b1, irq)
      rd(JCC_ADDR_MASK, 8'h03);
      wr(JCC_ADDR_STATUS, 8'h01);
      rd(JCC_ADDR_STATUS, 8'h00);
      rd(2'h3, 8'h00);
      `CHK("irq clear", 1'b0, irq)
   endtask
   task t_fail;
      @(posedge clk) configRequest_n <= 1'b0;
      settle(5);
      `CHK("done dropped", 1'b0, configComplete)
      @(posedge clk) configRequest_n <= 1'b1;
      settle(4);
      host.pulse(3, 1'b0);
      @(posedge clk) loadError <= 1'b1;
      settle(8);
      `CHK("error line", 1'b0, configErrorLine_n)
      `CHK("no done", 1'b0, configComplete)
      `CHK("enable held", 1'b1, chainEnableOut_n)
      rd(JCC_ADDR_STATUS, 8'h02);
      `CHK("irq fail", 1'b1, irq)
      @(posedge clk) loadError <= 1'b0;
      wr(JCC_ADDR_STATUS, 8'h02);
      settle(2);
      `CHK("irq cleared", 1'b0, irq)
      wr(JCC_ADDR_MASK, 8'h00);
      rd(JCC_ADDR_STATUS, 8'h00);
   endtask
   task t_bypass;
      @(posedge clk) bypassSel <= 1'b1;
      settle(2);
      host.pulse(1, 1'b1);
      settle(6);
      `CHK("tdo one", 1'b1, tdo)
      `CHK("tdo oe", 1'b1, tdoOe)
      host.pulse(1, 1'b0);
      settle(6);
      `CHK("tdo zero", 1'b0, tdo)
   endtask
   task report_and_stop;
      $display("errors %0d checks %0d", error_cnt, total_checks);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      settle(1);
      `CHK("reset enable", 1'b1, chainEnableOut_n)
      t_config;
      t_fail;
      t_bypass;
      report_and_stop;
   end
   // Whole run needs well under 10 us
   initial begin
      #50000;
      error_cnt++;
      report_and_stop;
   end
endmodule
